// ===== common/fitp_irq_if.sv
// Purpose: Carries synchronized request levels and detected events.
// Assumes: One clock domain.
// Notes: Source drives levels; detector drives events.
`timescale 1ns/1ps
interface fitp_irq_if #(parameter int N = 4);
  logic [N-1:0] req_low; // Synchronized active-low request levels
  logic [N-1:0] edge_mode; // One per line: 1 edge, 0 level
  logic [N-1:0] event_hit; // Detected request per line
  modport src (output req_low, output edge_mode, input event_hit);
  modport det (input req_low, input edge_mode, output event_hit);
endinterface : fitp_irq_if

// ===== common/fitp_params.svh
// Purpose: Offsets, reset values and timing counts.
// Assumes: Included by bare name; definitions only.
// Notes: One clock at 10 MHz.
`ifndef FITP_PARAMS_SVH
`define FITP_PARAMS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define FITP_OFS_FLAG_DIR 12'h000
`define FITP_OFS_FLAG_OUT 12'h004
`define FITP_OFS_FLAG_IN 12'h008
`define FITP_OFS_IRQ_EN 12'h00C
`define FITP_OFS_IRQ_MODE 12'h010
`define FITP_OFS_STRAP 12'h014
`define FITP_OFS_TMR_CTL 12'h018
`define FITP_OFS_INT_STAT 12'h01C
`define FITP_OFS_INT_CLR 12'h020
`define FITP_OFS_INT_EN 12'h024
// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define FITP_RST_NIBBLE 4'h0
`define FITP_PULSE_CYCLES 4
`define FITP_CLK_MHZ 10
`define FITP_ZERO32 32'h0000_0000
`endif

// ===== common/fitp_pkg.sv
// Purpose: Types shared by the pin block files.
// Assumes: Nothing imported; use fitp_pkg::name.
// Notes: States Gray coded along the pulse path.
package fitp_pkg;
  // ----------------------------------------
  // Expiry pulse states
  // ----------------------------------------
  typedef enum logic [1:0]
  {
    FITP_STRAP = 2'h0,
    FITP_IDLE = 2'h1,
    FITP_PULSE = 2'h3
  } fitp_pulse_e;
endpackage : fitp_pkg

// ===== rtl/fitp_irq_detect.sv
// Purpose: Per-line falling edge or low level detection.
// Assumes: Levels already synchronized.
// Notes: Edge history resets high, so no false edge at release.
`timescale 1ns/1ps
module fitp_irq_detect #(
  parameter int N = 4
)(
  input wire logic sys_clk, // System clock
  input wire logic rst, // Synchronous reset, high
  input wire logic ce, // Clock enable
  fitp_irq_if.det bus // Levels in, events out
);
  logic [N-1:0] prev; // Last sampled level
  logic [N-1:0] next_prev; // Next last level

  // History update
  always_comb
  begin
    next_prev = prev;
    if (rst)
      next_prev = '1;
    else if (ce)
      next_prev = bus.req_low;
  end

  always_ff @(posedge sys_clk)
  begin
    prev <= next_prev;
  end

  // One detector per line
  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_line
      // Edge: high then low; level: low now
      assign bus.event_hit[i] = bus.edge_mode[i] ?
        (prev[i] & ~bus.req_low[i]) : ~bus.req_low[i];
    end
  endgenerate
endmodule : fitp_irq_detect

// ===== rtl/fitp_pins.sv
// Purpose: Flag pins, interrupt request pins and timer expiry pin.
// Assumes: APB slave on sys_clk; timer sends one-cycle expiry pulse.
// Notes: Registers are one aligned word each; unmapped reads zero.
//
// Overview of operation
// - Each flag pin individually input or output.
// - Flags input, drivers off after reset.
// - Flag pin levels readable as conditions.
// - Enabled asserted request raises core interrupt.
// - Each request edge or level selectable.
// - Requests disabled after reset unless boot strap.
// - Expiry output pulses exactly PULSE cycles, four by default.
// - Expiry pin sampled as strap in reset.
`timescale 1ns/1ps
`include "fitp_params.svh"
module fitp_pins #(
  parameter int NFLAG = 4,
  parameter int NIRQ = 4,
  parameter int PULSE = `FITP_PULSE_CYCLES
)(
  input wire logic sys_clk, // System clock, 10 MHz
  input wire logic rst, // Synchronous reset, high
  input wire logic ce, // Clock enable, freezes state
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, always low
  input wire logic [NFLAG-1:0] program_condition_pins_i, // Flag pin in
  output logic [NFLAG-1:0] program_condition_pins_o, // Flag pin out
  output logic [NFLAG-1:0] program_condition_pins_oe, // Flag drive
  output logic [NFLAG-1:0] flag_cond, // Flag conditions
  input wire logic [NIRQ-1:0] interrupt_request_inputs_n, // Requests
  output logic [NIRQ-1:0] core_irq, // Request to core
  input wire logic boot_irq_strap, // Strap: boot via requests
  input wire logic timer_zero_expired, // Timer pulse, one cycle
  input wire logic timer_zero_expiry_out_i, // Expiry pin in
  output logic timer_zero_expiry_out_o, // Expiry pin out
  output logic timer_zero_expiry_out_oe, // Expiry pin drive
  output logic strap_tmr, // Sampled expiry strap
  output logic irq // Block interrupt
);
  // ----------------------------------------
  // Parameter checks
  // ----------------------------------------
  // Status needs one data bit per flag and per request
  if (NFLAG < 1 || NIRQ < 1 || NFLAG + NIRQ > 32 || PULSE < 1
      || PULSE > 15)
  begin : g_param_check
    $error("fitp_pins: unsupported parameter value");
  end

  localparam int SW = NIRQ + NFLAG; // Status width

  // ----------------------------------------
  // Synchronizers
  // ----------------------------------------
  logic [NFLAG-1:0] flag_sync; // Synchronized flag pins
  logic [NIRQ-1:0] req_sync; // Synchronized requests
  logic [1:0] strap_sync; // Synchronized boot and expiry straps

  fitp_sync #(.W(NFLAG), .INIT('0)) u_fsync (
    .sys_clk(sys_clk), .rst(rst), .ce(ce),
    .din(program_condition_pins_i), .dout(flag_sync));
  // Requests idle high, so INIT is high; rst is tied low, so this stage is never reset
  fitp_sync #(.W(NIRQ), .INIT('1)) u_isync (
    .sys_clk(sys_clk), .rst(1'b0), .ce(ce),
    .din(interrupt_request_inputs_n), .dout(req_sync));
  // Straps keep running through reset to catch their levels
  // Limitation: reset must outlast the pin release by three edges
  fitp_sync #(.W(2), .INIT('0)) u_ssync (
    .sys_clk(sys_clk), .rst(1'b0), .ce(ce),
    .din({boot_irq_strap, timer_zero_expiry_out_i}),
    .dout(strap_sync));

  // ----------------------------------------
  // Detection
  // ----------------------------------------
  fitp_irq_if #(.N(NIRQ)) ibus ();
  logic [NIRQ-1:0] irq_mode; // Edge mode per line
  assign ibus.req_low = req_sync;
  assign ibus.edge_mode = irq_mode;

  fitp_irq_detect #(.N(NIRQ)) u_det (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .bus(ibus));

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [NFLAG-1:0] flag_dir; // 1 output
  logic [NFLAG-1:0] flag_out; // Output values
  logic [NIRQ-1:0] irq_en; // Request enables
  logic [SW-1:0] int_stat; // Sticky events
  logic [SW-1:0] int_en; // Interrupt enables
  logic boot_strap_q; // Boot strap level in reset
  logic [NFLAG-1:0] flag_prev; // Last flag level
  logic [NFLAG-1:0] next_flag_dir, next_flag_out;
  logic [NIRQ-1:0] next_irq_en, next_irq_mode;
  logic [SW-1:0] next_int_stat, next_int_en;
  logic next_boot_strap, next_strap_tmr;
  logic [NFLAG-1:0] next_flag_prev;
  logic [31:0] next_prdata;
  logic wr_acc; // Write access phase
  logic rd_acc; // Read setup phase
  logic [SW-1:0] events; // New events this cycle

  // Writes land at the access edge; reads latch at setup
  assign wr_acc = psel & penable & pwrite & ce;
  assign rd_acc = psel & ~penable & ~pwrite;
  // Flag pins that changed while input, plus enabled detected requests
  assign events = {(flag_sync ^ flag_prev) & ~flag_dir,
                   ibus.event_hit & irq_en};

  // Register next values
  always_comb
  begin
    next_flag_dir = flag_dir;
    next_flag_out = flag_out;
    next_irq_en = irq_en;
    next_irq_mode = irq_mode;
    next_int_en = int_en;
    next_boot_strap = boot_strap_q;
    next_strap_tmr = strap_tmr;
    next_flag_prev = flag_prev;
    next_int_stat = int_stat;
    next_prdata = prdata;
    if (rst)
    begin
      next_flag_dir = `FITP_RST_NIBBLE;
      next_flag_out = '0;
      next_irq_mode = '0;
      next_int_en = '0;
      next_int_stat = '0;
      next_flag_prev = '0;
      next_prdata = `FITP_ZERO32;
      next_boot_strap = strap_sync[1]; // Caught while held
      next_strap_tmr = strap_sync[0];
      // Disabled unless strapped to boot via requests
      next_irq_en = strap_sync[1] ? '1 : '0;
    end
    else if (ce)
    begin
      next_flag_prev = flag_sync;
      if (wr_acc)
      begin
        unique case (paddr)
          `FITP_OFS_FLAG_DIR: next_flag_dir = pwdata[NFLAG-1:0];
          `FITP_OFS_FLAG_OUT: next_flag_out = pwdata[NFLAG-1:0];
          `FITP_OFS_IRQ_EN: next_irq_en = pwdata[NIRQ-1:0];
          `FITP_OFS_IRQ_MODE: next_irq_mode = pwdata[NIRQ-1:0];
          `FITP_OFS_INT_CLR: next_int_stat = int_stat & ~pwdata[SW-1:0];
          `FITP_OFS_INT_EN: next_int_en = pwdata[SW-1:0];
          default: ;
        endcase
      end
      // Set wins over a clear in the same cycle
      next_int_stat = next_int_stat | events;
      next_prdata = `FITP_ZERO32;
      if (rd_acc)
      begin
        unique case (paddr)
          `FITP_OFS_FLAG_DIR: next_prdata[NFLAG-1:0] = flag_dir;
          `FITP_OFS_FLAG_OUT: next_prdata[NFLAG-1:0] = flag_out;
          `FITP_OFS_FLAG_IN: next_prdata[NFLAG-1:0] = flag_sync;
          `FITP_OFS_IRQ_EN: next_prdata[NIRQ-1:0] = irq_en;
          `FITP_OFS_IRQ_MODE: next_prdata[NIRQ-1:0] = irq_mode;
          `FITP_OFS_STRAP: next_prdata[1:0] = {boot_strap_q, strap_tmr};
          `FITP_OFS_INT_STAT: next_prdata[SW-1:0] = int_stat;
          `FITP_OFS_INT_EN: next_prdata[SW-1:0] = int_en;
          default: next_prdata = `FITP_ZERO32; // Unmapped reads zero
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    flag_dir <= next_flag_dir;
    flag_out <= next_flag_out;
    irq_en <= next_irq_en;
    irq_mode <= next_irq_mode;
    int_en <= next_int_en;
    int_stat <= next_int_stat;
    boot_strap_q <= next_boot_strap;
    strap_tmr <= next_strap_tmr;
    flag_prev <= next_flag_prev;
    prdata <= next_prdata;
  end

  // ----------------------------------------
  // Pin and core outputs
  // ----------------------------------------
  logic [NFLAG-1:0] next_pins_o, next_pins_oe, next_cond;
  logic [NIRQ-1:0] next_core_irq;
  logic next_irq, next_pready;

  // Outputs registered to come straight from flops
  always_comb
  begin
    next_pins_o = program_condition_pins_o;
    next_pins_oe = program_condition_pins_oe;
    next_cond = flag_cond;
    next_core_irq = core_irq;
    next_irq = irq;
    next_pready = pready;
    if (rst)
    begin
      next_pins_o = '0;
      next_pins_oe = '0;
      next_cond = '0;
      next_core_irq = '0;
      next_irq = 1'b0;
      next_pready = 1'b0;
    end
    else if (ce)
    begin
      next_pins_o = next_flag_out;
      next_pins_oe = next_flag_dir;
      // Output pins report the driven level, inputs the pin
      next_cond = (flag_dir & flag_out) | (~flag_dir & flag_sync);
      next_core_irq = ibus.event_hit & irq_en;
      next_irq = |(next_int_stat & next_int_en);
      // Answer one cycle after setup: pready in access phase
      next_pready = psel & ~penable;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    program_condition_pins_o <= next_pins_o;
    program_condition_pins_oe <= next_pins_oe;
    flag_cond <= next_cond;
    core_irq <= next_core_irq;
    irq <= next_irq;
    pready <= next_pready;
  end

  assign pslverr = 1'b0;

  // ----------------------------------------
  // Timer expiry pulse
  // ----------------------------------------
  fitp_pkg::fitp_pulse_e pstate, next_pstate;
  logic [3:0] pcnt, next_pcnt; // Cycles left in pulse
  logic next_tmr_o, next_tmr_oe;

  // Pin floats in reset so it can be read as a strap
  always_comb
  begin
    next_pstate = pstate;
    next_pcnt = pcnt;
    next_tmr_o = 1'b0;
    next_tmr_oe = 1'b1;
    if (rst)
    begin
      next_pstate = fitp_pkg::FITP_STRAP;
      next_pcnt = '0;
      next_tmr_oe = 1'b0;
    end
    else if (!ce)
    begin
      next_tmr_o = timer_zero_expiry_out_o;
      next_tmr_oe = timer_zero_expiry_out_oe;
    end
    else
    begin
      unique case (pstate)
        fitp_pkg::FITP_STRAP: next_pstate = fitp_pkg::FITP_IDLE;
        fitp_pkg::FITP_IDLE:
          if (timer_zero_expired)
          begin
            next_pstate = fitp_pkg::FITP_PULSE;
            next_pcnt = 4'(PULSE - 1);
            next_tmr_o = 1'b1;
          end
        // Expiries inside a pulse are ignored
        fitp_pkg::FITP_PULSE:
          if (pcnt == '0)
            next_pstate = fitp_pkg::FITP_IDLE;
          else
          begin
            next_pcnt = pcnt - 4'h1;
            next_tmr_o = 1'b1;
          end
        default: next_pstate = fitp_pkg::FITP_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    pstate <= next_pstate;
    pcnt <= next_pcnt;
    timer_zero_expiry_out_o <= next_tmr_o;
    timer_zero_expiry_out_oe <= next_tmr_oe;
  end
endmodule : fitp_pins

// ===== rtl/fitp_sync.sv
// Purpose: Two-stage synchronizer for a bus of pin inputs.
// Assumes: Inputs asynchronous to sys_clk.
// Notes: First stage is read only by the second.
`timescale 1ns/1ps
module fitp_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] INIT = '0
)(
  input wire logic sys_clk, // System clock
  input wire logic rst, // Synchronous reset, high
  input wire logic ce, // Clock enable
  input wire logic [W-1:0] din, // Asynchronous input
  output logic [W-1:0] dout // Synchronized output
);
  logic [W-1:0] meta; // First stage
  logic [W-1:0] next_meta; // Next first stage
  logic [W-1:0] next_dout; // Next second stage

  // Next-value logic
  always_comb
  begin
    next_meta = meta;
    next_dout = dout;
    if (rst)
    begin
      next_meta = INIT;
      next_dout = INIT;
    end
    else if (ce)
    begin
      next_meta = din;
      next_dout = meta;
    end
  end

  // Registers only
  always_ff @(posedge sys_clk)
  begin
    meta <= next_meta;
    dout <= next_dout;
  end
endmodule : fitp_sync

// ===== sim/fitp_board.sv
// Purpose: Board side of the pins: drivers, pulls and straps.
// Assumes: Flags pulled down, requests pulled up.
// Notes: Contention is not modelled; bench avoids it.
`timescale 1ns/1ps
module fitp_board (
  input wire logic [3:0] flag_o, // Block flag drive
  input wire logic [3:0] flag_oe, // Block flag enable
  input wire logic [3:0] ext_val, // Board flag value
  input wire logic [3:0] ext_en, // Board flag enable
  input wire logic [3:0] req_low, // Board pulls request low
  input wire logic exp_o, // Block expiry drive
  input wire logic exp_oe, // Block expiry enable
  input wire logic strap_up, // Strap resistor level
  output logic [3:0] flag_pin, // Resolved flag wire
  output logic [3:0] req_n, // Resolved request wire
  output logic exp_pin // Resolved expiry wire
);
  // ----------------------------------------
  // Wire resolution, pull level when undriven
  // ----------------------------------------
  always_comb
  begin
    flag_pin = (flag_o & flag_oe) | (ext_val & ext_en & ~flag_oe);
    req_n = ~req_low;
    exp_pin = exp_oe ? exp_o : strap_up;
  end
endmodule : fitp_board

// ===== sim/fitp_pins_props.sv
// Purpose: Timing checks on the pin block ports.
// Assumes: Bound to fitp_pins; one clock domain.
// Notes: Flag check only holds while all flags are inputs.
`timescale 1ns/1ps
module fitp_pins_props #(
  parameter int NFLAG = 4,
  parameter int NIRQ = 4
)(
  input wire logic sys_clk, // Clock
  input wire logic rst, // Reset, high
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pready, // APB ready
  input wire logic [NFLAG-1:0] program_condition_pins_i, // Flag pin
  input wire logic [NFLAG-1:0] program_condition_pins_oe, // Flag drive
  input wire logic [NFLAG-1:0] flag_cond, // Flag conditions
  input wire logic [NIRQ-1:0] interrupt_request_inputs_n, // Requests
  input wire logic [NIRQ-1:0] core_irq, // Core requests
  input wire logic timer_zero_expired, // Timer pulse
  input wire logic timer_zero_expiry_out_o, // Expiry drive
  input wire logic timer_zero_expiry_out_oe, // Expiry enable
  input wire logic strap_tmr // Sampled strap
);
  logic [2:0] up; // Cycles since reset, saturating
  logic [2:0] next_up; // Next count
  // ----------------------------------------
  // Age counter: keeps $past away from reset
  // ----------------------------------------
  always_comb
  begin
    next_up = (up == 3'h7) ? up : up + 3'h1;
    if (rst)
    begin
      next_up = 3'h0;
    end
  end
  always_ff @(posedge sys_clk)
  begin
    up <= next_up;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_flag_rst;
    $fell(rst) |-> program_condition_pins_oe == '0;
  endproperty
  a_flag_rst: assert property (p_flag_rst)
    else $error("flag drive on");
  property p_exp_oe;
    $fell(rst) |-> !timer_zero_expiry_out_oe ##1 timer_zero_expiry_out_oe;
  endproperty
  a_exp_oe: assert property (p_exp_oe)
    else $error("expiry enable");
  property p_strap_hold; up > 3'h1 |-> $stable(strap_tmr); endproperty
  a_strap_hold: assert property (p_strap_hold)
    else $error("strap moved");
  property p_pulse_len;
    $rose(timer_zero_expiry_out_o) |->
      timer_zero_expiry_out_o [*4] ##1 !timer_zero_expiry_out_o;
  endproperty
  a_pulse_len: assert property (p_pulse_len)
    else $error("pulse length");
  property p_pulse_go;
    timer_zero_expired && timer_zero_expiry_out_oe && !timer_zero_expiry_out_o
      |=> timer_zero_expiry_out_o;
  endproperty
  a_pulse_go: assert property (p_pulse_go)
    else $error("no pulse");
  // Both modes: a request is only seen three edges after a low pin
  property p_req_sync;
    up > 3'h4 |-> (core_irq & $past(interrupt_request_inputs_n, 3)) == '0;
  endproperty
  a_req_sync: assert property (p_req_sync)
    else $error("request timing");
  property p_flag_sync;
    up > 3'h4 && program_condition_pins_oe == '0 &&
      $past(program_condition_pins_oe, 3) == '0
      |-> flag_cond == $past(program_condition_pins_i, 3);
  endproperty
  a_flag_sync: assert property (p_flag_sync)
    else $error("flag timing");
  property p_apb_ready; psel && !penable |=> pready ##1 !pready; endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("ready timing");
endmodule : fitp_pins_props
bind fitp_pins fitp_pins_props #(.NFLAG(NFLAG), .NIRQ(NIRQ))
  fitp_pins_props_inst (.sys_clk(sys_clk), .rst(rst), .psel(psel),
  .penable(penable), .pready(pready),
  .program_condition_pins_i(program_condition_pins_i),
  .program_condition_pins_oe(program_condition_pins_oe),
  .flag_cond(flag_cond),
  .interrupt_request_inputs_n(interrupt_request_inputs_n),
  .core_irq(core_irq), .timer_zero_expired(timer_zero_expired),
  .timer_zero_expiry_out_o(timer_zero_expiry_out_o),
  .timer_zero_expiry_out_oe(timer_zero_expiry_out_oe),
  .strap_tmr(strap_tmr));

// ===== sim/flag_irq_timer_pins_bench.sv
// Purpose: Register level tests of the pin block.
// Assumes: Master waits on pready; no fixed wait count.
// Notes: Strap resets hold four edges so the straps settle.
`timescale 1ns/1ps
`include "fitp_params.svh"
module flag_irq_timer_pins_bench;
  logic sys_clk = 0, rst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000; // Address
  logic [31:0] pwdata = 32'h0, prdata, q; // Data
  logic pready, pslverr, boot = 0, texp = 0, exp_i, exp_o, exp_oe;
  logic strap_tmr, irq, strap_up = 0; // Straps and interrupt
  logic [3:0] fi, fo, foe, fcond, req_n, core, ev = 0, ee = 0, rl = 0;
  int miscompares = 0, checked = 0, cnt [4], tc;
  int exp_cnt [4] = '{1, 10, 0, 10}; // Edge, level, off, level
  always #50 sys_clk = ~sys_clk;
  fitp_pins #(.NFLAG(4), .NIRQ(4), .PULSE(4)) fitp_pins_inst (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .program_condition_pins_i(fi),
    .program_condition_pins_o(fo), .program_condition_pins_oe(foe),
    .flag_cond(fcond), .interrupt_request_inputs_n(req_n), .core_irq(core),
    .boot_irq_strap(boot), .timer_zero_expired(texp),
    .timer_zero_expiry_out_i(exp_i), .timer_zero_expiry_out_o(exp_o),
    .timer_zero_expiry_out_oe(exp_oe), .strap_tmr(strap_tmr), .irq(irq));
  fitp_board fitp_board_inst (.flag_o(fo), .flag_oe(foe), .ext_val(ev),
    .ext_en(ee), .req_low(rl), .exp_o(exp_o), .exp_oe(exp_oe),
    .strap_up(strap_up), .flag_pin(fi), .req_n(req_n), .exp_pin(exp_i));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want)
    begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : chk
  // One APB transfer, then an idle cycle so strobes never double up
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb
  task rdc(input logic [11:0] a, input logic [31:0] want);
    apb(1'b0, a, 32'h0);
    chk(q, want);
  endtask : rdc
  // Four edges: a driven expiry pin is only released at the first
  task do_reset(input logic b, input logic e);
    rst <= 1'b1;
    boot <= b;
    strap_up <= e;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
  endtask : do_reset
  task test_done;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done
  // ----------------------------------------
  // Watchdog, far beyond the expected run
  // ----------------------------------------
  initial
  begin
    #1000000;
    miscompares++;
    test_done();
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    // Plain two-cycle power-on reset first
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    do_reset(1'b1, 1'b0); // Boot strap high, expiry strap low
    chk(strap_tmr, 32'h0);
    rdc(`FITP_OFS_STRAP, 32'h2);
    rdc(`FITP_OFS_IRQ_EN, 32'hF);
    chk(foe, 32'h0);
    do_reset(1'b0, 1'b1); // Mid-run reset, expiry pin was driven
    chk(strap_tmr, 32'h1);
    rdc(`FITP_OFS_STRAP, 32'h1);
    rdc(`FITP_OFS_IRQ_EN, 32'h0);
    rdc(`FITP_OFS_FLAG_DIR, 32'h0);
    rdc(12'h018, 32'h0);
    rdc(12'hFFC, 32'h0);
    $display("test reset ended");
    // Board drives pins 1 and 3 while all flags are inputs
    ev <= 4'h2;
    ee <= 4'hA;
    repeat (6) @(posedge sys_clk);
    chk(fcond, 32'h2);
    apb(1'b1, `FITP_OFS_FLAG_DIR, 32'h5);
    apb(1'b1, `FITP_OFS_FLAG_OUT, 32'hF);
    repeat (4) @(posedge sys_clk);
    chk(foe, 32'h5);
    chk(fo, 32'hF);
    chk(fi, 32'h7);
    chk(fcond, 32'h7);
    rdc(`FITP_OFS_FLAG_IN, 32'h7);
    $display("test flags ended");
    // Lines 0, 2 edge; line 2 disabled; all held low ten cycles
    apb(1'b1, `FITP_OFS_INT_CLR, 32'hFF);
    apb(1'b1, `FITP_OFS_IRQ_EN, 32'hB);
    apb(1'b1, `FITP_OFS_IRQ_MODE, 32'h5);
    apb(1'b1, `FITP_OFS_INT_EN, 32'h0);
    cnt = '{0, 0, 0, 0};
    for (int i = 0; i < 16; i++)
    begin
      rl <= (i < 10) ? 4'hF : 4'h0;
      @(posedge sys_clk);
      for (int j = 0; j < 4; j++)
        cnt[j] += core[j];
    end
    for (int j = 0; j < 4; j++)
      chk(cnt[j], exp_cnt[j]);
    chk(irq, 32'h0);
    rdc(`FITP_OFS_INT_STAT, 32'hB);
    apb(1'b1, `FITP_OFS_INT_EN, 32'hF);
    repeat (2) @(posedge sys_clk);
    chk(irq, 32'h1);
    apb(1'b1, `FITP_OFS_INT_CLR, 32'hFF);
    repeat (2) @(posedge sys_clk);
    chk(irq, 32'h0);
    rdc(`FITP_OFS_INT_STAT, 32'h0);
    $display("test interrupts ended");
    // Second expiry two cycles into the pulse must be ignored
    tc = 0;
    for (int i = 0; i < 12; i++)
    begin
      texp <= (i == 0 || i == 2);
      @(posedge sys_clk);
      tc += exp_i;
    end
    chk(tc, `FITP_PULSE_CYCLES);
    chk(exp_i, 32'h0);
    $display("test expiry ended");
    test_done();
  end
endmodule : flag_irq_timer_pins_bench
